// *** design/srp_pkg.sv ***
// Shared constants for the serial register port.
package srp_pkg;

  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;
  localparam int MEM_DEPTH = 32;

  // Instruction byte layout.
  localparam int INSTR_DIR_BIT = 7;
  localparam int INSTR_CNT_MSB = 6;
  localparam int INSTR_CNT_LSB = 5;
  localparam int INSTR_ADDR_MSB = 4;

  // Position of the pin-count select bit in the interface configuration.
  localparam int PIN_SEL_BIT = 6;

  // Bit counter value of the last bit in a byte.
  localparam logic [2:0] BIT_LAST = 3'h7;

  // Registers kept in the core clock domain.
  localparam logic [4:0] ADDR_STICKY = 5'h02;
  localparam logic [4:0] ADDR_CFG = 5'h03;
  localparam logic [4:0] ADDR_STATUS = 5'h1f;

  localparam logic [7:0] CFG_RST = 8'h10;
  localparam logic [7:0] STICKY_RST = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'h00;

  typedef enum logic [1:0] {
    SRP_INSTR,
    SRP_DATA,
    SRP_DONE
  } srp_phase_e;

endpackage : srp_pkg

// *** design/srp_mem_if.sv ***
// Link-side access path between the port logic and the register memory.
`timescale 1ns/1ps
interface srp_mem_if;
  import srp_pkg::*;

  logic we;
  logic [ADDR_W-1:0] waddr;
  logic [DATA_W-1:0] wdata;
  logic re;
  logic [ADDR_W-1:0] raddr;
  logic [DATA_W-1:0] rdata;

  modport port (
    output we,
    output waddr,
    output wdata,
    output re,
    output raddr,
    input rdata
  );

  modport mem (
    input we,
    input waddr,
    input wdata,
    input re,
    input raddr,
    output rdata
  );

endinterface : srp_mem_if

// *** design/srp_sync.sv ***
// Two-flop synchroniser for independent level signals.
`timescale 1ns/1ps
module srp_sync
  import srp_pkg::*;
#(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  // The first stage feeds the second stage only.
  always_ff @(posedge clk) begin
    meta_q <= d;
    q <= meta_q;
  end

endmodule : srp_sync

// *** design/srp_regmem.sv ***
// Byte-wide register memory on the serial clock with registered read data.
`timescale 1ns/1ps
module srp_regmem
  import srp_pkg::*;
(
  input wire logic clk,
  srp_mem_if.mem bus
);

  // No reset: the array holds whatever software last wrote.
  logic [DATA_W-1:0] mem_q [MEM_DEPTH];

  always_ff @(posedge clk) begin
    if (bus.we) begin
      mem_q[bus.waddr] <= bus.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (bus.re) begin
      bus.rdata <= mem_q[bus.raddr];
    end
  end

endmodule : srp_regmem

// *** design/srp_port.sv ***
// Serial register port: frame decoding, register file and pin drivers.
`timescale 1ns/1ps
module srp_port
  import srp_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic sclk,
  input wire logic frame_enable_n,
  input wire logic sdio_i,
  output logic sdio_o,
  output logic sdio_oe,
  output logic sdo_o,
  output logic sdo_oe,
  input wire logic [7:0] status_in,
  input wire logic [7:0] event_set,
  output logic [7:0] interface_config,
  output logic [7:0] sticky_flags
);

  // ---------------- Core clock domain ----------------

  logic link_clr_q;
  logic wtog_core;
  logic wtog_seen_q;
  logic wr_evt;
  logic [7:0] cfg_q;
  logic [7:0] sticky_q;
  logic [7:0] status_q;
  logic [7:0] sticky_clr;
  logic fe_n_core;
  logic [23:0] snap_q;

  // Link-side signals declared here because the core side reads them.
  logic wtog_q;
  logic [ADDR_W-1:0] wr_addr_q;
  logic [DATA_W-1:0] wr_data_q;

  // Registered reset, used only to clear the write toggle on the link side.
  always_ff @(posedge core_clk) begin
    link_clr_q <= srst;
  end

  srp_sync #(
    .W(1)
  ) u_wtog_sync (
    .clk(core_clk),
    .d(wtog_q),
    .q(wtog_core)
  );

  always_ff @(posedge core_clk) begin
    if (srst) begin
      wtog_seen_q <= 1'b0;
    end else begin
      wtog_seen_q <= wtog_core;
    end
  end

  // Address and data are stable long before the toggle arrives here.
  assign wr_evt = wtog_core ^ wtog_seen_q;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cfg_q <= CFG_RST;
    end else if (wr_evt && wr_addr_q == ADDR_CFG) begin
      cfg_q <= wr_data_q;
    end
  end

  always_comb begin
    sticky_clr = 8'h00;
    if (wr_evt && wr_addr_q == ADDR_STICKY) begin
      sticky_clr = ~wr_data_q;
    end
  end

  // A set in the same cycle as a clear wins.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sticky_q <= STICKY_RST;
    end else begin
      sticky_q <= (sticky_q & ~sticky_clr) | event_set;
    end
  end

  // Status is read-only; serial writes to its address never reach it.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      status_q <= STATUS_RST;
    end else begin
      status_q <= status_in;
    end
  end

  assign interface_config = cfg_q;
  assign sticky_flags = sticky_q;

  // Frame enable is a pin, so the core sees it only through two flops.
  srp_sync #(
    .W(1)
  ) u_fe_sync (
    .clk(core_clk),
    .d(frame_enable_n),
    .q(fe_n_core)
  );

  // Frozen while a frame runs, so the serial side never sees a torn word.
  // The cost: a status change during a frame shows only in the next one.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      snap_q <= {CFG_RST, STICKY_RST, STATUS_RST};
    end else if (fe_n_core) begin
      snap_q <= {cfg_q, sticky_q, status_q};
    end
  end

  // ---------------- Serial clock domain ----------------

  srp_phase_e phase_q;
  logic [2:0] bit_cnt_q;
  logic [1:0] bytes_left_q;
  logic dir_read_q;
  logic [ADDR_W-1:0] addr_q;
  logic [6:0] in_sh_q;
  logic [7:0] instr;
  logic [7:0] din;
  logic last_bit;
  logic wr_fire;
  logic [ADDR_W-1:0] rd_addr;
  logic [ADDR_W-1:0] raddr_q;
  logic [23:0] core_s;
  logic [7:0] cfg_s;
  logic [7:0] sticky_s;
  logic [7:0] status_s;
  logic four_wire_select;
  logic [7:0] rbyte;
  logic [6:0] out_sh_q;
  logic dout_q;
  logic sdio_oe_q;
  logic sdo_oe_q;

  srp_mem_if mem_bus ();

  srp_regmem u_regmem (
    .clk(sclk),
    .bus(mem_bus)
  );

  // The snapshot stands still during a frame, so per-bit sync is safe.
  srp_sync #(
    .W(24)
  ) u_core_sync (
    .clk(sclk),
    .d(snap_q),
    .q(core_s)
  );

  assign cfg_s = core_s[23:16];
  assign sticky_s = core_s[15:8];
  assign status_s = core_s[7:0];
  assign four_wire_select = cfg_s[PIN_SEL_BIT];

  assign instr = {in_sh_q, sdio_i};
  assign din = {in_sh_q, sdio_i};
  assign last_bit = (bit_cnt_q == BIT_LAST);
  assign wr_fire = (phase_q == SRP_DATA) && last_bit && !dir_read_q;

  // The next byte is fetched on the rising edge that ends the previous one.
  always_comb begin
    if (phase_q == SRP_INSTR) begin
      rd_addr = instr[INSTR_ADDR_MSB:0];
    end else begin
      rd_addr = addr_q - 5'h01;
    end
  end

  // Frame enable high clears all frame state, so a partial byte is dropped.
  always_ff @(posedge sclk or posedge frame_enable_n) begin
    if (frame_enable_n) begin
      phase_q <= SRP_INSTR;
      bit_cnt_q <= 3'h0;
      bytes_left_q <= 2'h0;
      dir_read_q <= 1'b0;
      addr_q <= 5'h00;
      in_sh_q <= 7'h00;
    end else begin
      in_sh_q <= {in_sh_q[5:0], sdio_i};
      bit_cnt_q <= bit_cnt_q + 3'h1;
      case (phase_q)
        SRP_INSTR: begin
          if (last_bit) begin
            phase_q <= SRP_DATA;
            dir_read_q <= instr[INSTR_DIR_BIT];
            bytes_left_q <= instr[INSTR_CNT_MSB:INSTR_CNT_LSB];
            addr_q <= instr[INSTR_ADDR_MSB:0];
          end
        end
        SRP_DATA: begin
          if (last_bit) begin
            addr_q <= addr_q - 5'h01;
            if (bytes_left_q == 2'h0) begin
              phase_q <= SRP_DONE;
            end else begin
              bytes_left_q <= bytes_left_q - 2'h1;
            end
          end
        end
        default: begin
          phase_q <= SRP_DONE;
        end
      endcase
    end
  end

  // Config and sticky are written through the toggle; no core-owned register is written to the memory.
  assign mem_bus.we = wr_fire && addr_q != ADDR_CFG &&
                      addr_q != ADDR_STICKY && addr_q != ADDR_STATUS;
  assign mem_bus.waddr = addr_q;
  assign mem_bus.wdata = din;
  assign mem_bus.re = last_bit && phase_q != SRP_DONE;
  assign mem_bus.raddr = rd_addr;

  always_ff @(posedge sclk) begin
    if (mem_bus.re) begin
      raddr_q <= rd_addr;
    end
  end

  // Held after the frame so the core can pick the word up at leisure.
  always_ff @(posedge sclk) begin
    if (wr_fire) begin
      wr_addr_q <= addr_q;
      wr_data_q <= din;
    end
  end

  always_ff @(posedge sclk or posedge link_clr_q) begin
    if (link_clr_q) begin
      wtog_q <= 1'b0;
    end else if (wr_fire) begin
      wtog_q <= ~wtog_q;
    end
  end

  always_comb begin
    if (raddr_q == ADDR_CFG) begin
      rbyte = cfg_s;
    end else if (raddr_q == ADDR_STICKY) begin
      rbyte = sticky_s;
    end else if (raddr_q == ADDR_STATUS) begin
      rbyte = status_s;
    end else begin
      rbyte = mem_bus.rdata;
    end
  end

  // Output side moves on falling edges so the host samples on rising ones.
  always_ff @(negedge sclk or posedge frame_enable_n) begin
    if (frame_enable_n) begin
      dout_q <= 1'b0;
      out_sh_q <= 7'h00;
      sdio_oe_q <= 1'b0;
      sdo_oe_q <= 1'b0;
    end else if (dir_read_q && phase_q == SRP_DATA) begin
      if (bit_cnt_q == 3'h0) begin
        dout_q <= rbyte[7];
        out_sh_q <= rbyte[6:0];
      end else begin
        dout_q <= out_sh_q[6];
        out_sh_q <= {out_sh_q[5:0], 1'b0};
      end
      sdio_oe_q <= !four_wire_select;
      sdo_oe_q <= four_wire_select;
    end else if (dir_read_q && phase_q == SRP_DONE) begin
      dout_q <= 1'b0;
      sdio_oe_q <= 1'b0;
      sdo_oe_q <= 1'b1;
    end
  end

  assign sdio_o = dout_q;
  assign sdo_o = dout_q;
  assign sdio_oe = sdio_oe_q;
  assign sdo_oe = sdo_oe_q;

endmodule : srp_port

// *** verif/srp_monitor.sv ***
// Pin and register checks on the serial register port.
`timescale 1ns/1ps
module srp_monitor (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic sclk,
  input wire logic frame_enable_n,
  input wire logic sdio_i,
  input wire logic sdio_o,
  input wire logic sdio_oe,
  input wire logic sdo_o,
  input wire logic sdo_oe,
  input wire logic [7:0] event_set,
  input wire logic [7:0] interface_config,
  input wire logic [7:0] sticky_flags
);
  logic [5:0] cnt_q;
  logic [7:0] ins_q;
  logic rd_bit;
  logic tail;
  always_ff @(posedge sclk or posedge frame_enable_n) begin
    if (frame_enable_n) begin
      cnt_q <= 6'h00;
    end else begin
      cnt_q <= cnt_q + 6'h01;
    end
  end
  always_ff @(posedge sclk) begin
    if (cnt_q < 6'h08) begin
      ins_q <= {ins_q[6:0], sdio_i};
    end
  end
  assign rd_bit = ins_q[7] && cnt_q >= 6'h08
    && cnt_q < 6'h10 + {1'b0, ins_q[6:5], 3'h0};
  assign tail = ins_q[7] && cnt_q == 6'h10 + {1'b0, ins_q[6:5], 3'h0};
  chk_oe_exclusive: assert property (
    @(posedge core_clk) disable iff (srst) !(sdio_oe && sdo_oe))
    else $error("both data pins driven");
  chk_fall_only: assert property (
    @(posedge core_clk) disable iff (srst) !frame_enable_n
    && $changed({sdio_o, sdo_o, sdio_oe, sdo_oe}) |-> !sclk)
    else $error("output changed while serial clock high");
  chk_idle_release: assert property (
    @(posedge core_clk) disable iff (srst)
    frame_enable_n |-> !sdio_oe && !sdo_oe)
    else $error("pin driven outside a frame");
  chk_tail_low: assert property (
    @(posedge core_clk) disable iff (srst)
    !frame_enable_n && !sclk && tail |-> sdo_oe && !sdo_o)
    else $error("serial out not low after last read bit");
  chk_four_pin_read: assert property (
    @(posedge sclk) disable iff (srst || frame_enable_n)
    rd_bit && interface_config[6] |-> sdo_oe && !sdio_oe)
    else $error("four-pin read not on serial out");
  chk_three_pin_read: assert property (
    @(posedge sclk) disable iff (srst || frame_enable_n)
    rd_bit && !interface_config[6] |-> sdio_oe && !sdo_oe)
    else $error("three-pin read not on data pin");
  chk_quiet_otherwise: assert property (
    @(posedge sclk) disable iff (srst || frame_enable_n)
    cnt_q < 6'h08 || !ins_q[7] |-> !sdio_oe && !sdo_oe)
    else $error("pin driven during instruction or write");
  chk_sticky_set: assert property (
    @(posedge core_clk) disable iff (srst) event_set != 8'h00
    |=> (sticky_flags & $past(event_set)) == $past(event_set))
    else $error("event not captured in sticky flags");
endmodule : srp_monitor

// *** verif/srp_host.sv ***
// Serial master model that frames transfers into the port.
`timescale 1ns/1ps
module srp_host (
  output logic sclk,
  output logic frame_enable_n,
  output logic sdio_i,
  input wire logic sdio_o,
  input wire logic sdio_oe,
  input wire logic sdo_o,
  input wire logic sdo_oe
);
  logic hb;
  // A released data wire toggles, so a stale bit can never pass a read.
  assign sdio_i = sdio_oe ? sdio_o : hb;
  // A rising frame enable is the only reset of the port's frame logic.
  initial begin
    sclk = 1'b0;
    hb = 1'b0;
    frame_enable_n = 1'b0;
    #1 frame_enable_n = 1'b1;
  end
  // Byte k of the data phase travels in d[31-8k -: 8].
  task automatic frame(input logic [7:0] ins, input int nb,
    input logic four, inout logic [31:0] d);
    int i;
    #5 frame_enable_n = 1'b0;
    for (i = 0; i < nb; i++) begin
      if (i < 8) hb = ins[7 - i];
      else if (!ins[7]) hb = d[39 - i];
      else hb = ~hb;
      #24 sclk = 1'b1;
      if (i >= 8 && ins[7]) d[39 - i] = four ? (sdo_oe ? sdo_o : 1'bx)
        : (sdio_oe ? sdio_o : 1'bx);
      #24 sclk = 1'b0;
    end
    #5 frame_enable_n = 1'b1;
    hb = ~hb;
    #20;
  endtask : frame
endmodule : srp_host

// *** verif/srp_port_tb_top.sv ***
// Top-level bench for the serial register port.
`timescale 1ns/1ps
module srp_port_tb_top;
  import srp_pkg::*;
  logic core_clk, srst, sclk, frame_enable_n, sdio_i;
  logic sdio_o, sdio_oe, sdo_o, sdo_oe;
  logic [7:0] status_in, event_set, interface_config, sticky_flags;
  logic [31:0] d;
  int n_fail, compares, m;
  srp_port dut (
    .core_clk(core_clk),
    .srst(srst),
    .sclk(sclk),
    .frame_enable_n(frame_enable_n),
    .sdio_i(sdio_i),
    .sdio_o(sdio_o),
    .sdio_oe(sdio_oe),
    .sdo_o(sdo_o),
    .sdo_oe(sdo_oe),
    .status_in(status_in),
    .event_set(event_set),
    .interface_config(interface_config),
    .sticky_flags(sticky_flags)
  );
  srp_host host (
    .sclk(sclk),
    .frame_enable_n(frame_enable_n),
    .sdio_i(sdio_i),
    .sdio_o(sdio_o),
    .sdio_oe(sdio_oe),
    .sdo_o(sdo_o),
    .sdo_oe(sdo_oe)
  );
  // The half-ns offset puts core edges on half-ns times; frames start on one, so each sclk edge lands 1 ns off a core edge.
  initial begin
    core_clk = 1'b0;
    #0.5;
    forever #2 core_clk = ~core_clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_of_test();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test
  task automatic wr(input logic [4:0] a, input logic [1:0] n,
    input logic [31:0] v);
    logic [31:0] t;
    t = v;
    host.frame({1'b0, n, a}, 16 + 8 * n, m[0], t);
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [1:0] n,
    input logic [31:0] exp);
    logic [31:0] t;
    t = 32'h0;
    host.frame({1'b1, n, a}, 16 + 8 * n, m[0], t);
    chk(t, exp);
  endtask : rd
  initial begin
    #100000;
    n_fail++;
    end_of_test();
  end
  initial begin
    srst = 1'b1;
    event_set = 8'h00;
    status_in = 8'h5a;
    n_fail = 0;
    compares = 0;
    m = 0;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk) srst = 1'b0;
    chk(32'(interface_config), 32'(CFG_RST));
    chk(32'(sticky_flags), 32'(STICKY_RST));
    repeat (4) @(posedge core_clk);
    for (m = 0; m < 2; m++) begin
      wr(ADDR_CFG, 2'h0, {m[0] ? 8'h50 : 8'h10, 24'h0});
      repeat (10) @(posedge core_clk);
      chk(32'(interface_config[6]), 32'(m[0]));
      wr(5'h0a, 2'h3, 32'h1234_abcd ^ 32'(m));
      rd(5'h0a, 2'h3, 32'h1234_abcd ^ 32'(m));
      rd(5'h08, 2'h1, {16'habcd ^ 16'(m), 16'h0});
      rd(5'h09, 2'h2, {24'h34_abcd ^ 24'(m), 8'h0});
      d = 32'h0;
      host.frame({3'h0, 5'h0a}, 12, m[0], d);
      rd(5'h0a, 2'h0, 32'h1200_0000);
      @(negedge core_clk) status_in = 8'h5a ^ 8'(m);
      wr(ADDR_STATUS, 2'h0, 32'hff00_0000);
      rd(ADDR_STATUS, 2'h0, {status_in, 24'h0});
      @(negedge core_clk) event_set = 8'h81;
      @(negedge core_clk) event_set = 8'h00;
      chk(32'(sticky_flags), 32'h81);
      rd(ADDR_STICKY, 2'h0, 32'h8100_0000);
      wr(ADDR_STICKY, 2'h0, 32'h8000_0000);
      repeat (10) @(posedge core_clk);
      chk(32'(sticky_flags), 32'h80);
      $display("mode %0d test done", m);
    end
    end_of_test();
  end
endmodule : srp_port_tb_top
bind srp_port srp_monitor mon (
  .core_clk(core_clk),
  .srst(srst),
  .sclk(sclk),
  .frame_enable_n(frame_enable_n),
  .sdio_i(sdio_i),
  .sdio_o(sdio_o),
  .sdio_oe(sdio_oe),
  .sdo_o(sdo_o),
  .sdo_oe(sdo_oe),
  .event_set(event_set),
  .interface_config(interface_config),
  .sticky_flags(sticky_flags)
);
